// file: rtl/bapd_map.vh
// Constants for the bridge arm driver protection block
`ifndef BAPD_MAP_VH
`define BAPD_MAP_VH
`define BAPD_CNT_W       24
`define BAPD_CLK_MHZ     200
`define BAPD_MINPW_US    200
`define BAPD_DEAD_US     2
`define BAPD_BLANK_US    5
`define BAPD_MINPW_CYC   (`BAPD_MINPW_US * `BAPD_CLK_MHZ)
`define BAPD_DEAD_CYC    (`BAPD_DEAD_US * `BAPD_CLK_MHZ)
`define BAPD_BLANK_CYC   (`BAPD_BLANK_US * `BAPD_CLK_MHZ)
`define BAPD_CNT_ZERO    24'h000000
`define BAPD_CNT_ONE     24'h000001
`define BAPD_SYNC_ZERO   7'h00
`define BAPD_ST_OFF      2'h0
`define BAPD_ST_DEAD     2'h1
`define BAPD_ST_UPPER    2'h2
`define BAPD_ST_LOWER    2'h3
`endif

// file: rtl/bapd_filter.v
// Two-stage synchroniser and minimum pulse width filter for one command input
`include "bapd_map.vh"
`default_nettype none
module bapd_filter (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Raw command and minimum width in cycles
  input  wire        cmd_i,
  input  wire [23:0] min_width_i,
  // Filtered command
  output reg         cmd_o
);
  reg        sync_a;
  reg        sync_b;
  reg [23:0] run_cnt;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      run_cnt <= `BAPD_CNT_ZERO;
      cmd_o   <= 1'b0;
    end else begin
      sync_a <= cmd_i;
      sync_b <= sync_a;
      // Level must stay stable for the full width before it is accepted
      if (sync_b == cmd_o) begin
        run_cnt <= `BAPD_CNT_ZERO;
      end else if (run_cnt + `BAPD_CNT_ONE >= min_width_i) begin
        cmd_o   <= sync_b;
        run_cnt <= `BAPD_CNT_ZERO;
      end else begin
        run_cnt <= run_cnt + `BAPD_CNT_ONE;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/bapd_top.v
// Half-bridge gate driver protection: filters, interlock, dead time, fault latch
//
// Summary of operation
// - Overcurrent or desaturation while a gate is on latches a fault; both gates off until reset.
// - The fault latch state is reported to the controller as a status output.
// - Gate clamp events neither latch a fault nor turn gates off.
// - Bus overvoltage monitor, when enabled, latches a fault.
// - Overtemperature comparator latches a fault.
// - Gate or internal supply undervoltage latches a fault.
// - Command pulses shorter than the minimum width are ignored.
// - Upper and lower gates are never on together, even with overlapping commands.
// - A programmable dead time separates one switch off and the other on.
// - Desaturation and overcurrent inputs are blanked after each turn-on.
// - Blanking count is capped by a short-circuit withstand limit parameter.
`include "bapd_map.vh"
`default_nettype none
module bapd_top #(
  parameter [23:0] MINPW_CYC    = `BAPD_MINPW_CYC,
  parameter [23:0] DEAD_CYC     = `BAPD_DEAD_CYC,
  parameter [23:0] BLANK_CYC    = `BAPD_BLANK_CYC,
  parameter [23:0] WITHSTAND_CYC = `BAPD_BLANK_CYC
) (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire rst_i,
  // Controller commands and fault reset
  input  wire upper_cmd_i,
  input  wire lower_cmd_i,
  input  wire fault_reset_i,
  input  wire bus_mon_en_i,
  // Comparator inputs
  input  wire overcurrent_i,
  input  wire desat_i,
  input  wire bus_overvolt_i,
  input  wire overtemp_i,
  input  wire undervolt_i,
  input  wire gate_clamp_i,
  // Gate enables and status
  output reg  upper_gate_o,
  output reg  lower_gate_o,
  output reg  fault_o,
  output reg  clamp_active_o
);
  // Synchroniser stages for the comparator and reset inputs
  reg [6:0] s1;
  reg [6:0] s2;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [23:0] dead_cnt;
  reg [23:0] blank_cnt;
  reg        fault;
  wire       up_f;
  wire       lo_f;
  wire [23:0] blank_lim;

  // Counter step of the dead time counter; the blanking counter steps down with bapd_dec
  function [23:0] bapd_inc;
    input [23:0] val;
    begin
      bapd_inc = val + `BAPD_CNT_ONE;
    end
  endfunction

  function [23:0] bapd_dec;
    input [23:0] val;
    begin
      bapd_dec = val - `BAPD_CNT_ONE;
    end
  endfunction

  // True on the last cycle of a count of lim cycles
  function bapd_done;
    input [23:0] val;
    input [23:0] lim;
    begin
      bapd_done = (bapd_inc(val) >= lim);
    end
  endfunction

  // A gate may be on only in its own state and with nothing stopping it
  function bapd_gate_on;
    input [1:0] st;
    input [1:0] want;
    input       stop;
    begin
      bapd_gate_on = (st == want) && !stop;
    end
  endfunction

  // Blanking never exceeds the withstand time of the transistor
  // Withstand cap
  assign blank_lim = (BLANK_CYC > WITHSTAND_CYC) ? WITHSTAND_CYC : BLANK_CYC;

  bapd_filter u_up (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .cmd_i       (upper_cmd_i),
    .min_width_i (MINPW_CYC),
    .cmd_o       (up_f)
  );
  bapd_filter u_lo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .cmd_i       (lower_cmd_i),
    .min_width_i (MINPW_CYC),
    .cmd_o       (lo_f)
  );

  wire oc_q    = s2[0];
  wire ds_q    = s2[1];
  wire bus_q   = s2[2];
  wire ot_q    = s2[3];
  wire uv_q    = s2[4];
  wire clamp_q = s2[5];
  wire frst_q  = s2[6];
  wire blanked = (blank_cnt != `BAPD_CNT_ZERO);
  wire on_now  = (state == `BAPD_ST_UPPER) || (state == `BAPD_ST_LOWER);

  wire sc_evt  = on_now && !blanked && (oc_q || ds_q);
  wire any_evt = sc_evt || (bus_mon_en_i && bus_q) || ot_q || uv_q;
  // Fresh events act at once, before the latch output is seen
  wire stop_all = fault || any_evt;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1 <= `BAPD_SYNC_ZERO;
      s2 <= `BAPD_SYNC_ZERO;
    end else begin
      s1 <= {fault_reset_i, gate_clamp_i, undervolt_i, overtemp_i,
             bus_overvolt_i, desat_i, overcurrent_i};
      s2 <= s1;
    end
  end

  // Fault latch; a new event wins over the reset request
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault <= 1'b0;
    end else if (any_evt) begin
      fault <= 1'b1;
    end else if (frst_q) begin
      fault <= 1'b0;
    end
  end

  // Gate sequencer next state
  always @* begin
    next_state = state;
    case (state)
      `BAPD_ST_OFF: begin
        if (!stop_all && (up_f ^ lo_f)) begin
          next_state = up_f ? `BAPD_ST_UPPER : `BAPD_ST_LOWER;
        end
      end
      `BAPD_ST_DEAD: begin
        if (bapd_done(dead_cnt, DEAD_CYC)) begin
          next_state = `BAPD_ST_OFF;
        end
      end
      `BAPD_ST_UPPER: begin
        if (stop_all || !up_f || lo_f) begin
          next_state = `BAPD_ST_DEAD;
        end
      end
      default: begin
        if (stop_all || !lo_f || up_f) begin
          next_state = `BAPD_ST_DEAD;
        end
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= `BAPD_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      dead_cnt <= `BAPD_CNT_ZERO;
    end else if ((state != `BAPD_ST_DEAD) || (next_state != `BAPD_ST_DEAD)) begin
      dead_cnt <= `BAPD_CNT_ZERO;
    end else begin
      dead_cnt <= bapd_inc(dead_cnt);
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      blank_cnt <= `BAPD_CNT_ZERO;
    end else if ((state == `BAPD_ST_OFF) && (next_state != `BAPD_ST_OFF)) begin
      blank_cnt <= blank_lim;
    end else if (blank_cnt != `BAPD_CNT_ZERO) begin
      blank_cnt <= bapd_dec(blank_cnt);
    end
  end

  // Registered outputs; clamp only reported, never acts on gates
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      upper_gate_o   <= 1'b0;
      lower_gate_o   <= 1'b0;
      fault_o        <= 1'b0;
      clamp_active_o <= 1'b0;
    end else begin
      upper_gate_o   <= bapd_gate_on(state, `BAPD_ST_UPPER, stop_all);
      lower_gate_o   <= bapd_gate_on(state, `BAPD_ST_LOWER, stop_all);
      fault_o        <= fault;
      clamp_active_o <= clamp_q;
    end
  end
endmodule
`default_nettype wire

// file: test/bapd_ctl_model.sv
// Controller model driving the two switch commands
`default_nettype none
module bapd_ctl_model (
  input  wire logic clk_sys_i,
  output var  logic upper_cmd_o,
  output var  logic lower_cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    upper_cmd_o = 1'b0;
    lower_cmd_o = 1'b0;
  end
  // Levels change only on an edge and stand n whole cycles
  task automatic drive(input logic up, input logic lo, input int n);
    @(posedge clk_sys_i);
    upper_cmd_o <= up;
    lower_cmd_o <= lo;
    repeat (n - 1) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// file: test/bapd_top_sva.sv
// Assertions watching the half-bridge protection ports
`default_nettype none
module bapd_top_sva (
  input wire logic clk_sys_i, rst_i, fault_reset_i, bus_mon_en_i,
  input wire logic bus_overvolt_i, overtemp_i, undervolt_i,
  input wire logic upper_gate_o, lower_gate_o, fault_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence held_ev;
    (overtemp_i || undervolt_i || bus_overvolt_i && bus_mon_en_i)[*6];
  endsequence
  no_overlap_a: assert property (!(upper_gate_o && lower_gate_o))
    else $error("both gates on");
  fault_off_a: assert property (fault_o |-> !upper_gate_o && !lower_gate_o)
    else $error("gate on in fault");
  fault_hold_a: assert property (fault_o && !fault_reset_i && !$past(fault_reset_i)
    && !$past(fault_reset_i, 2) && !$past(fault_reset_i, 3) |=> fault_o)
    else $error("fault dropped early");
  fault_clear_a: assert property ($fell(fault_o) |-> $past(fault_reset_i, 4))
    else $error("fault cleared unasked");
  event_latch_a: assert property (held_ev |-> fault_o)
    else $error("event not latched");
  dead_up_a: assert property ($fell(upper_gate_o) |-> !lower_gate_o[*4])
    else $error("dead time short");
  dead_lo_a: assert property ($fell(lower_gate_o) |-> !upper_gate_o[*4])
    else $error("dead time short");
  reset_off_a: assert property (disable iff (1'b0) rst_i |=> !upper_gate_o && !lower_gate_o)
    else $error("gate on after reset");
endmodule
bind bapd_top bapd_top_sva chk (.clk_sys_i, .rst_i, .fault_reset_i, .bus_mon_en_i,
  .bus_overvolt_i, .overtemp_i, .undervolt_i, .upper_gate_o, .lower_gate_o, .fault_o);
`default_nettype wire

// file: test/bapd_top_tb.sv
// Testbench for the half-bridge protection block
`default_nettype none
module bapd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_i = 1, fres = 0, bus_en = 0;
  logic [5:0] ev = 6'h00;
  logic [31:0] seed = 32'h40;
  wire logic up_cmd, lo_cmd, up_g, lo_g, flt, clamp;
  int error_cnt = 0, n_compared = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  bapd_ctl_model ctl (.clk_sys_i, .upper_cmd_o(up_cmd), .lower_cmd_o(lo_cmd));
  bapd_top #(.MINPW_CYC(24'h8), .DEAD_CYC(24'h4), .BLANK_CYC(24'h6), .WITHSTAND_CYC(24'hA)) uut (
    .clk_sys_i, .rst_i, .upper_cmd_i(up_cmd), .lower_cmd_i(lo_cmd), .fault_reset_i(fres),
    .bus_mon_en_i(bus_en), .overcurrent_i(ev[0]), .desat_i(ev[1]), .bus_overvolt_i(ev[2]),
    .overtemp_i(ev[3]), .undervolt_i(ev[4]), .gate_clamp_i(ev[5]), .upper_gate_o(up_g),
    .lower_gate_o(lo_g), .fault_o(flt), .clamp_active_o(clamp));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Gate model: own command only, no fault
  function automatic logic gm(int own, int other, int f);
    return own != 0 && other == 0 && f == 0;
  endfunction
  task automatic chk(input string nm, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #10us;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 0;
    #1;
    chk("up", up_g, 0);
    ctl.drive(1, 0, 4);
    ctl.drive(0, 0, 20);
    #1;
    chk("up", up_g, 0);
    ctl.drive(1, 0, 16 + rnd() % 8);
    #1;
    chk("up", up_g, gm(1, 0, 0));
    ctl.drive(1, 1, 20);
    #1;
    chk("both", up_g | lo_g, 0);
    ctl.drive(0, 1, 20);
    #1;
    chk("lo", lo_g, gm(1, 0, 0));
    ctl.drive(0, 0, 20);
    ctl.drive(1, 0, 1);
    // Gate rises 12 edges after the command; glitch lands in blanking
    repeat (12) @(posedge clk_sys_i);
    ev[1] <= 1'b1;
    @(posedge clk_sys_i);
    ev[1] <= 1'b0;
    #1;
    chk("up", up_g, 1);
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk("flt", flt, 0);
    @(posedge clk_sys_i);
    ev[1] <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk("up", up_g, 0);
    ctl.drive(0, 0, 12);
    for (int k = 0; k < 7; k++) begin
      ev <= 6'h00;
      fres <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      #1;
      chk("flt", flt, 0);
      @(posedge clk_sys_i);
      fres <= 1'b0;
      bus_en <= (k == 2);
      ev[(k == 6) ? 2 : k] <= 1'b1;
      repeat (6 + rnd() % 4) @(posedge clk_sys_i);
      #1;
      chk("flt", flt, k >= 2 && k < 5);
      chk("clamp", clamp, k == 5);
      @(posedge clk_sys_i);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
